/* design/frbp_pkg.sv */
// Package of constants and types for the repeat-block and pipeline control.
package frbp_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0]  ADDR_LOOP_STATE = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_CONTROL    = 4'h8;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

  // ==========================================================================
  // Field positions of the loop state word
  // ==========================================================================
  localparam int SAVED_BIT    = 31;
  localparam int ACTIVE_BIT   = 30;
  localparam int SIZE_LSB     = 23;
  localparam int END_LSB      = 16;
  localparam int COUNT_LSB    = 0;
  localparam int SIZE_W       = 7;
  localparam int COUNT_W      = 16;
  localparam int PC_W         = 22;
  localparam logic [31:0] LOOP_STATE_RESET = 32'h0000_0000;
  localparam logic [PC_W-1:0] PC_RESET     = 22'h3F_FFC0;

  // ==========================================================================
  // Pipeline classes and latencies
  // ==========================================================================
  localparam logic [2:0] CLASS_CPU      = 3'h0;
  localparam logic [2:0] CLASS_FP_MATH  = 3'h1;
  localparam logic [2:0] CLASS_FP_CONV  = 3'h2;
  localparam logic [2:0] CLASS_FP_ONE   = 3'h3;
  localparam int         EXTRA_CYCLES   = 1;
  localparam int         REG_COUNT      = 8;

  // ==========================================================================
  // Bus slave state
  // ==========================================================================
  typedef enum logic [1:0] {
    FRBP_BUS_IDLE = 2'b01,
    FRBP_BUS_DONE = 2'b10
  } frbp_bus_state_t;

endpackage : frbp_pkg

/* design/frbp_result_mem.sv */
// Writeback-result memory of the floating-point register file.
`timescale 1ns/1ps
module frbp_result_mem (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        wr_en_in,
  input  wire logic [2:0]  wr_addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic [2:0]  rd_addr_in,
  output logic      [31:0] rd_data_out
);

  logic [31:0] mem [0:frbp_pkg::REG_COUNT-1];

  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 32'h0000_0000;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule : frbp_result_mem

/* design/frbp_pipeline_ctrl.sv */
// Repeat-block loop control and floating-point pipeline timing.
`timescale 1ns/1ps
//
// Contract
// RL1: interrupt saves active flag, clears active
// RL2: interrupt return restores active, clears saved
// RL3: nonzero count sets active; zero clears it
// RL4: word count bits 29:23 loaded from instruction
// RL5: source uses block sizes 8 to 127
// RL6: end pointer is low seven of pc+1+size
// RL7: zero count runs block once, no active
// RL8: count decrements at block end; count+1 runs
// RL9: active loop redirects fetch to block start
// RL10: loop state writable only by hardware
// RL11: second decode splits CPU from FPU instructions
// RL12: CPU stalls stall the FPU identically
// RL13: some instructions use one extra execute cycle
// RL14: pipelined ops issue every cycle, result later
// RL15: math operations have one delay slot
// RL16: conversions have one delay slot
// RL17: min max compare move have no slot
// RL18: stream aligns FPU to CPU copies
// RL19: stream waits four cycles after CPU copy
module frbp_pipeline_ctrl (
  input  wire logic                          clock_in,
  input  wire logic                          rst_n_in,
  input  wire logic [3:0]                    avs_address_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  input  wire logic [31:0]                   avs_writedata_in,
  input  wire logic [3:0]                    avs_byteenable_in,
  output logic      [31:0]                   avs_readdata_out,
  output logic                               avs_waitrequest_out,
  input  wire logic                          cpu_stall_in,
  input  wire logic                          d2_valid_in,
  input  wire logic                          d2_is_fpu_in,
  input  wire logic [2:0]                    d2_class_in,
  input  wire logic [2:0]                    d2_dest_in,
  input  wire logic [31:0]                   d2_result_in,
  input  wire logic [frbp_pkg::PC_W-1:0]     d2_pc_in,
  input  wire logic                          block_loop_in,
  input  wire logic [frbp_pkg::SIZE_W-1:0]   block_size_in,
  input  wire logic [frbp_pkg::COUNT_W-1:0]  block_count_in,
  input  wire logic                          interrupt_take_in,
  input  wire logic                          interrupt_return_in,
  output logic                               cpu_issue_out,
  output logic                               fpu_issue_out,
  output logic                               fetch_redirect_out,
  output logic      [frbp_pkg::PC_W-1:0]     fetch_target_out,
  output logic                               wb_valid_out,
  output logic      [2:0]                    wb_dest_out,
  output logic      [31:0]                   wb_data_out,
  output logic                               loop_active_out
);

  // ==========================================================================
  // Loop state
  // ==========================================================================
  logic                              loop_active;
  logic                              saved_loop_flag;
  logic [frbp_pkg::SIZE_W-1:0]       block_word_count;
  logic [frbp_pkg::SIZE_W-1:0]       block_end_pointer;
  logic [frbp_pkg::COUNT_W-1:0]      loop_count;
  logic [frbp_pkg::PC_W-1:0]         block_start;
  logic [31:0]                       repeat_loop_state;
  logic                              step;
  logic                              at_end;
  logic [31:0]                       stall_count;
  logic [31:0]                       conflict_count;

  function automatic logic [frbp_pkg::SIZE_W-1:0] end_of_block(
    input logic [frbp_pkg::PC_W-1:0]   pc,
    input logic [frbp_pkg::SIZE_W-1:0] size
  );
    logic [frbp_pkg::PC_W-1:0] sum;
    sum = pc + 22'h00_0001 + {15'h0000, size};
    return sum[frbp_pkg::SIZE_W-1:0];
  endfunction : end_of_block

  // The pipeline advances only when the CPU side advances.
  assign step   = !cpu_stall_in; // RL12
  assign at_end = step && d2_valid_in && !block_loop_in
                  && (d2_pc_in[frbp_pkg::SIZE_W-1:0] == block_end_pointer);

  // Each field is placed by its position so the word layout lives in the package.
  always_comb begin
    repeat_loop_state = frbp_pkg::LOOP_STATE_RESET;
    repeat_loop_state[frbp_pkg::SAVED_BIT]  = saved_loop_flag;
    repeat_loop_state[frbp_pkg::ACTIVE_BIT] = loop_active;
    repeat_loop_state[frbp_pkg::SIZE_LSB+:frbp_pkg::SIZE_W]   = block_word_count;
    repeat_loop_state[frbp_pkg::END_LSB+:frbp_pkg::SIZE_W]    = block_end_pointer;
    repeat_loop_state[frbp_pkg::COUNT_LSB+:frbp_pkg::COUNT_W] = loop_count;
  end

  // Interrupt handling takes priority over active-flag updates in the same cycle; count and fields still update.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      loop_active     <= 1'b0;
      saved_loop_flag <= 1'b0;
    end else if (interrupt_take_in) begin
      saved_loop_flag <= loop_active; // RL1
      loop_active     <= 1'b0; // RL1
    end else if (interrupt_return_in) begin
      loop_active     <= saved_loop_flag; // RL2
      saved_loop_flag <= 1'b0; // RL2
    end else if (step && block_loop_in) begin
      loop_active <= (block_count_in != 16'h0000); // RL3 RL7
    end else if (at_end && loop_active && loop_count == 16'h0001) begin
      loop_active <= 1'b0; // RL3 RL8
    end
  end

  // Only hardware fills these fields; bus writes never reach them.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      block_word_count  <= 7'h00;
      block_end_pointer <= 7'h00;
      block_start       <= frbp_pkg::PC_RESET;
    end else if (step && block_loop_in) begin
      block_word_count  <= block_size_in; // RL4 RL10
      block_end_pointer <= end_of_block(d2_pc_in, block_size_in); // RL6
      block_start       <= d2_pc_in + 22'h00_0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      loop_count <= 16'h0000;
    end else if (step && block_loop_in) begin
      loop_count <= block_count_in; // RL8
    end else if (at_end && loop_active && loop_count != 16'h0000) begin
      loop_count <= loop_count - 16'h0001; // RL8
    end
  end

  // Redirect while still active; the last pass falls through the end.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      fetch_redirect_out <= 1'b0;
      fetch_target_out   <= frbp_pkg::PC_RESET;
    end else begin
      fetch_redirect_out <= at_end && loop_active && !interrupt_take_in; // RL9
      fetch_target_out   <= block_start; // RL9
    end
  end

  assign loop_active_out = loop_active;

  // ==========================================================================
  // Decode split and execute stages
  // ==========================================================================
  logic        e2_valid;
  logic [2:0]  e2_dest;
  logic [31:0] e2_data;
  logic        two_cycle;
  logic        fpu_go;

  assign two_cycle = (d2_class_in == frbp_pkg::CLASS_FP_MATH) // RL15
                     || (d2_class_in == frbp_pkg::CLASS_FP_CONV); // RL16
  assign fpu_go    = step && d2_valid_in && d2_is_fpu_in;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cpu_issue_out <= 1'b0;
      fpu_issue_out <= 1'b0;
    end else begin
      cpu_issue_out <= step && d2_valid_in && !d2_is_fpu_in; // RL11
      fpu_issue_out <= fpu_go; // RL11
    end
  end

  // Two-cycle operations park in the extra stage; a new one may enter
  // every cycle since the stage holds only one result at a time.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      e2_valid <= 1'b0;
      e2_dest  <= 3'h0;
      e2_data  <= 32'h0000_0000;
    end else if (step) begin
      e2_valid <= fpu_go && two_cycle; // RL13 RL14
      e2_dest  <= d2_dest_in;
      e2_data  <= d2_result_in;
    end
  end

  // Single-cycle results retire now unless a two-cycle one is pending in e2; two-cycle ones one step later.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      wb_valid_out <= 1'b0;
      wb_dest_out  <= 3'h0;
      wb_data_out  <= 32'h0000_0000;
    end else if (!step) begin
      wb_valid_out <= 1'b0; // RL12
    end else if (e2_valid) begin
      wb_valid_out <= 1'b1; // RL14
      wb_dest_out  <= e2_dest;
      wb_data_out  <= e2_data;
    end else begin
      wb_valid_out <= fpu_go && !two_cycle; // RL17
      wb_dest_out  <= d2_dest_in;
      wb_data_out  <= d2_result_in;
    end
  end

  // A same-cycle retire and single-cycle issue means the stream broke
  // its alignment; it is counted for software, not interlocked.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      conflict_count <= 32'h0000_0000;
    end else if (step && e2_valid && fpu_go && !two_cycle) begin
      conflict_count <= conflict_count + 32'h0000_0001; // RL18 RL19
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      stall_count <= 32'h0000_0000;
    end else if (!step) begin
      stall_count <= stall_count + 32'h0000_0001;
    end
  end

  frbp_result_mem u_result_mem (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .wr_en_in    (wb_valid_out),
    .wr_addr_in  (wb_dest_out),
    .wr_data_in  (wb_data_out),
    .rd_addr_in  (avs_writedata_in[2:0]),
    .rd_data_out ()
  );

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, then the answer
  // ==========================================================================
  frbp_pkg::frbp_bus_state_t bus_state;
  logic [31:0]               next_readdata;

  always_comb begin
    unique case (avs_address_in)
      frbp_pkg::ADDR_LOOP_STATE: next_readdata = repeat_loop_state;
      frbp_pkg::ADDR_STATUS:     next_readdata = stall_count;
      frbp_pkg::ADDR_CONTROL:    next_readdata = conflict_count;
      default:                   next_readdata = frbp_pkg::UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      bus_state           <= frbp_pkg::FRBP_BUS_IDLE;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else begin
      unique case (bus_state)
        frbp_pkg::FRBP_BUS_IDLE: begin
          if (avs_read_in || avs_write_in) begin
            bus_state           <= frbp_pkg::FRBP_BUS_DONE;
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out    <= avs_read_in ? next_readdata : 32'h0000_0000;
          end
        end
        frbp_pkg::FRBP_BUS_DONE: begin
          bus_state           <= frbp_pkg::FRBP_BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
        default: begin
          bus_state           <= frbp_pkg::FRBP_BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  irq_save_a: assert property (interrupt_take_in |=> !loop_active // RL1
      && saved_loop_flag == $past(loop_active)) else $error("interrupt save wrong");
  irq_return_a: assert property (!interrupt_take_in && interrupt_return_in
      |=> !saved_loop_flag && loop_active == $past(saved_loop_flag)) // RL2
      else $error("interrupt return wrong");
  loop_start_a: assert property (step && block_loop_in && !interrupt_take_in
      && !interrupt_return_in |=> loop_active == ($past(block_count_in) != 16'h0000)) // RL3
      else $error("loop start flag wrong");
  size_load_a: assert property (step && block_loop_in
      |=> block_word_count == $past(block_size_in)) // RL4
      else $error("size not loaded");
  end_ptr_a: assert property (step && block_loop_in |=> block_end_pointer // RL6
      == end_of_block($past(d2_pc_in), $past(block_size_in))) else $error("end pointer wrong");
  count_dec_a: assert property (at_end && loop_active && loop_count != 16'h0000
      && !block_loop_in |=> loop_count == $past(loop_count) - 16'h0001) // RL8
      else $error("count not decremented");
  redirect_a: assert property (at_end && loop_active && !interrupt_take_in
      |=> fetch_redirect_out && fetch_target_out == $past(block_start)) // RL9
      else $error("no redirect");
  state_hold_a: assert property (!(step && block_loop_in) |=> $stable(block_end_pointer)) // RL10
      else $error("loop state changed");
  split_a: assert property (step && d2_valid_in |=> cpu_issue_out != fpu_issue_out) // RL11
      else $error("decode split wrong");
  stall_a: assert property (cpu_stall_in |=> !wb_valid_out && !fpu_issue_out) // RL12
      else $error("stall not followed");
  two_cycle_a: assert property (fpu_go && two_cycle ##1 step |=> wb_valid_out // RL14
      && wb_dest_out == $past(d2_dest_in, 2)) else $error("two-cycle late");
  one_cycle_a: assert property (fpu_go && !two_cycle && !e2_valid |=> wb_valid_out) // RL17
      else $error("single-cycle late");

  // Two-cycle results wait in the extra stage and never retire one cycle early.
  extra_stage_a: assert property (fpu_go && two_cycle |=> e2_valid) // RL13
      else $error("extra stage skipped");
  math_slot_a: assert property (fpu_go && d2_class_in == frbp_pkg::CLASS_FP_MATH // RL15
      && !e2_valid |=> !wb_valid_out) else $error("math result early");
  conv_slot_a: assert property (fpu_go && d2_class_in == frbp_pkg::CLASS_FP_CONV // RL16
      && !e2_valid |=> !wb_valid_out) else $error("conversion result early");
  wb_retire_a: assert property (step && e2_valid // RL14
      |=> wb_valid_out && wb_data_out == $past(e2_data)) else $error("pending result lost");
  stall_hold_a: assert property (cpu_stall_in // RL12
      |=> $stable(loop_count) && $stable(e2_valid)) else $error("state moved in stall");
  zero_count_a: assert property (step && block_loop_in && block_count_in == 16'h0000 // RL7
      && !interrupt_take_in && !interrupt_return_in |=> !loop_active)
      else $error("zero count set active");
  loop_clear_a: assert property (at_end && loop_active && loop_count == 16'h0001 // RL3
      && !interrupt_take_in && !interrupt_return_in |=> !loop_active && loop_count == 16'h0000)
      else $error("loop not cleared");
  count_load_a: assert property (step && block_loop_in // RL8
      |=> loop_count == $past(block_count_in)) else $error("count not loaded");

  // The slave answers once, one cycle after the request.
  bus_answer_a: assert property (bus_state == frbp_pkg::FRBP_BUS_IDLE
      && (avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
      else $error("bus not answered");
  bus_single_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("answer held too long");
  read_data_a: assert property (bus_state == frbp_pkg::FRBP_BUS_IDLE && avs_read_in
      && avs_address_in == frbp_pkg::ADDR_LOOP_STATE
      |=> avs_readdata_out == $past(repeat_loop_state)) else $error("read data wrong");

  loop_run_c: cover property (block_loop_in && step ##[1:200] fetch_redirect_out);
  read_c:     cover property (avs_read_in && !avs_waitrequest_out);
  irq_nest_c: cover property (interrupt_take_in ##[1:20] interrupt_return_in);
  pipe_c:     cover property (fpu_go && two_cycle ##1 fpu_go && two_cycle);
  stall_c:    cover property (cpu_stall_in [*3]);

endmodule : frbp_pipeline_ctrl

/* bench/frbp_host_model.sv */
// Behavioural instruction stream of the host pipeline that feeds second decode.
`timescale 1ns/1ps
module frbp_host_model (
  input  wire logic                      clock_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      stall_in,
  input  wire logic                      redirect_in,
  input  wire logic [frbp_pkg::PC_W-1:0] target_in,
  output logic                           d2_valid_out,
  output logic      [frbp_pkg::PC_W-1:0] d2_pc_out
);
  // ==========================================================================
  // Fetch sequencing
  // ==========================================================================
  // A redirect wins over a stall so that the loop start is never skipped.
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      d2_valid_out <= 1'b0;
      d2_pc_out    <= frbp_pkg::PC_RESET;
    end else begin
      d2_valid_out <= 1'b1;
      if (redirect_in) begin
        d2_pc_out <= target_in;
      end else if (!stall_in) begin
        d2_pc_out <= d2_pc_out + 22'h1;
      end
    end
  end
endmodule : frbp_host_model

/* bench/fpu_repeat_block_pipeline_bench.sv */
// Self-checking bench for the repeat-block loop and the pipeline timing.
`timescale 1ns/1ps
`define FRBP_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t: mismatch got %h exp %h", $time, (g), (e)); end end
module fpu_repeat_block_pipeline_bench;
  logic clock_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, d2_result_in = 32'h0, rd;
  logic avs_waitrequest_out, cpu_stall_in = 1'b0, d2_valid, d2_is_fpu_in = 1'b0;
  logic [2:0] d2_class_in = 3'h0, d2_dest_in = 3'h0, wb_dest_out, e_d, p_d;
  logic [21:0] d2_pc, fetch_target_out, exp_tgt = 22'h0, tmp;
  logic [6:0] block_size_in = 7'h0, exp_end;
  logic [15:0] block_count_in = 16'h0;
  logic block_loop_in = 1'b0, interrupt_take_in = 1'b0, interrupt_return_in = 1'b0;
  logic cpu_issue_out, fpu_issue_out, fetch_redirect_out, wb_valid_out, loop_active_out;
  logic [31:0] wb_data_out, e_r, p_r;
  logic e_cpu, e_fpu, e_wb, p_v, hz;
  logic [1:0] cls;
  int n_fail = 0, total_checks = 0, n_redir = 0, n_stall = 0, i, k;
  integer seed = 32'hA10C, r;

  always #50 clock_in = ~clock_in;

  frbp_pipeline_ctrl u_frbp_pipeline_ctrl (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .cpu_stall_in(cpu_stall_in), .d2_valid_in(d2_valid), .d2_is_fpu_in(d2_is_fpu_in),
    .d2_class_in(d2_class_in), .d2_dest_in(d2_dest_in), .d2_result_in(d2_result_in),
    .d2_pc_in(d2_pc), .block_loop_in(block_loop_in), .block_size_in(block_size_in),
    .block_count_in(block_count_in), .interrupt_take_in(interrupt_take_in),
    .interrupt_return_in(interrupt_return_in), .cpu_issue_out(cpu_issue_out),
    .fpu_issue_out(fpu_issue_out), .fetch_redirect_out(fetch_redirect_out),
    .fetch_target_out(fetch_target_out), .wb_valid_out(wb_valid_out),
    .wb_dest_out(wb_dest_out), .wb_data_out(wb_data_out), .loop_active_out(loop_active_out));

  frbp_host_model u_frbp_host_model (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .stall_in(cpu_stall_in), .redirect_in(fetch_redirect_out), .target_in(fetch_target_out),
    .d2_valid_out(d2_valid), .d2_pc_out(d2_pc));

  // ==========================================================================
  // Reference model of issue and writeback, compared every cycle
  // ==========================================================================
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      e_cpu <= 1'b0; e_fpu <= 1'b0; e_wb <= 1'b0; p_v <= 1'b0;
    end else if (cpu_stall_in) begin
      e_cpu <= 1'b0; e_fpu <= 1'b0; e_wb <= 1'b0;
    end else begin
      e_cpu <= d2_valid && !d2_is_fpu_in;
      e_fpu <= d2_valid && d2_is_fpu_in;
      if (d2_valid && d2_is_fpu_in && d2_class_in == frbp_pkg::CLASS_FP_ONE) begin
        e_wb <= 1'b1; e_d <= d2_dest_in; e_r <= d2_result_in;
      end else begin
        e_wb <= p_v; e_d <= p_d; e_r <= p_r;
      end
      p_v <= d2_valid && d2_is_fpu_in && (d2_class_in == frbp_pkg::CLASS_FP_MATH ||
             d2_class_in == frbp_pkg::CLASS_FP_CONV);
      p_d <= d2_dest_in; p_r <= d2_result_in;
    end
    if (rst_n_in && fetch_redirect_out === 1'b1) begin
      n_redir++;
      `FRBP_CHK(fetch_target_out, exp_tgt)
    end
    if (rst_n_in && cpu_stall_in === 1'b1) n_stall++;
  end

  always @(negedge clock_in) begin
    if (rst_n_in) begin
      `FRBP_CHK(cpu_issue_out, e_cpu)
      `FRBP_CHK(fpu_issue_out, e_fpu)
      `FRBP_CHK(wb_valid_out, e_wb)
      if (e_wb) begin
        `FRBP_CHK(wb_dest_out, e_d)
        `FRBP_CHK(wb_data_out, e_r)
      end
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic close_out();
    $display("Counts: %0d checks, %0d failures", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int w;
    @(posedge clock_in);
    avs_write_in <= wr; avs_read_in <= !wr; avs_address_in <= a; avs_writedata_in <= wd;
    w = 0;
    do begin @(posedge clock_in); w++; end while (avs_waitrequest_out !== 1'b0 && w < 20);
    if (w >= 20) begin n_fail++; $display("Error at %0t: bus hang", $time); close_out(); end
    rd = avs_readdata_out;
    avs_read_in <= 1'b0; avs_write_in <= 1'b0;
  endtask : bus

  task automatic load(input logic [6:0] s, input logic [15:0] n);
    @(posedge clock_in);
    exp_tgt = d2_pc + 22'h2;
    tmp = exp_tgt + {15'h0, s};
    exp_end = tmp[6:0];
    block_loop_in <= 1'b1; block_size_in <= s; block_count_in <= n; n_redir = 0;
    @(posedge clock_in);
    block_loop_in <= 1'b0;
    @(negedge clock_in);
    `FRBP_CHK(loop_active_out, n != 16'h0)
  endtask : load

  task automatic pulse(input logic ret);
    @(posedge clock_in);
    if (ret) interrupt_return_in <= 1'b1; else interrupt_take_in <= 1'b1;
    @(posedge clock_in);
    interrupt_return_in <= 1'b0; interrupt_take_in <= 1'b0;
  endtask : pulse

  task automatic run_out(input int n);
    k = 0;
    while (loop_active_out === 1'b1 && k < 3000) begin @(posedge clock_in); k++; end
    if (k >= 3000) begin n_fail++; $display("Error at %0t: loop hang", $time); close_out(); end
    repeat (140) @(posedge clock_in);
    `FRBP_CHK(n_redir, n)
    bus(1'b0, frbp_pkg::ADDR_LOOP_STATE, 32'h0);
    `FRBP_CHK(rd[31:30], 2'b00)
    `FRBP_CHK(rd[15:0], 16'h0)
  endtask : run_out

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    bus(1'b0, frbp_pkg::ADDR_LOOP_STATE, 32'h0);
    `FRBP_CHK(rd, frbp_pkg::LOOP_STATE_RESET)
    bus(1'b0, 4'hC, 32'h0);
    `FRBP_CHK(rd, frbp_pkg::UNMAPPED_DATA)
    $display("Test reset done");
    for (i = 0; i < 3; i++) begin
      r = $random(seed);
      k = 1 + (r[9:8]);
      load(7'd12 + 7'(r[6:0] % 116), 16'(k));
      bus(1'b1, frbp_pkg::ADDR_LOOP_STATE, 32'hFFFF_FFFF);
      bus(1'b0, frbp_pkg::ADDR_LOOP_STATE, 32'h0);
      `FRBP_CHK(rd, {2'b01, block_size_in, exp_end, 16'(k)})
      run_out(k);
    end
    $display("Test repeat loop done");
    load(7'd20, 16'h0);
    run_out(0);
    $display("Test zero count done");
    load(7'd40, 16'h2);
    pulse(1'b0);
    @(negedge clock_in);
    `FRBP_CHK(loop_active_out, 1'b0)
    bus(1'b0, frbp_pkg::ADDR_LOOP_STATE, 32'h0);
    `FRBP_CHK(rd[31:30], 2'b10)
    pulse(1'b1);
    @(negedge clock_in);
    `FRBP_CHK(loop_active_out, 1'b1)
    bus(1'b0, frbp_pkg::ADDR_LOOP_STATE, 32'h0);
    `FRBP_CHK(rd[31:30], 2'b01)
    run_out(2);
    $display("Test interrupt shadow done");
    for (i = 0; i < 400; i++) begin
      @(posedge clock_in);
      r = $random(seed);
      hz = ((d2_class_in == frbp_pkg::CLASS_FP_MATH || d2_class_in == frbp_pkg::CLASS_FP_CONV)
            && !cpu_stall_in) || (p_v && cpu_stall_in);
      cls = r[1:0];
      if (hz && cls == 2'h3) cls = 2'h0;
      cpu_stall_in <= (r[4:3] == 2'b00);
      d2_class_in <= {1'b0, cls};
      d2_is_fpu_in <= (cls != 2'h0);
      d2_dest_in <= r[7:5];
      d2_result_in <= $random(seed);
    end
    @(posedge clock_in);
    cpu_stall_in <= 1'b0; d2_class_in <= 3'h0; d2_is_fpu_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    bus(1'b0, frbp_pkg::ADDR_STATUS, 32'h0);
    `FRBP_CHK(rd, 32'(n_stall))
    bus(1'b0, frbp_pkg::ADDR_CONTROL, 32'h0);
    `FRBP_CHK(rd, 32'h0000_0000)
    $display("Test pipeline timing done");
    close_out();
  end
endmodule : fpu_repeat_block_pipeline_bench
